// ==== eeiu_defs.svh ====
`ifndef EEIU_DEFS_SVH
`define EEIU_DEFS_SVH
// ==========================================
// register selects on the host register port
`define EEIU_SEL_EN    2'h0
`define EEIU_SEL_FLAG  2'h1
`define EEIU_SEL_PEN   2'h2
`define EEIU_SEL_PFLAG 2'h3
// ==========================================
// enable and flag bit positions
`define EEIU_B_GIE  7
`define EEIU_B_PKT  6
`define EEIU_B_DMA  5
`define EEIU_B_LNK  4
`define EEIU_B_TXD  3
`define EEIU_B_RSV  2
`define EEIU_B_TXE  1
`define EEIU_B_RXE  0
// phy enable and phy flag bit positions
`define EEIU_B_PLNK 4
`define EEIU_B_PGEN 1
`define EEIU_B_PHY_GLOBAL_FLAG 2
// ==========================================
// masks and reset values
`define EEIU_EN_WMASK  8'hfb
`define EEIU_FLG_CMASK 8'h2b
`define EEIU_PEN_WMASK 16'h0012
`define EEIU_RST8      8'h00
`define EEIU_RST16     16'h0000
`define EEIU_PKT_MAX   8'hff
`define EEIU_PKT_ONE   8'h01
`define EEIU_PTR_ONE   1
// ==========================================
// deferral limit, 2.4287 ms, at a 20 ns clock
`define EEIU_UNLIMITED_WAIT_ENABLE_NS  2428700
`define EEIU_CLK_NS    20
`define EEIU_UNLIMITED_WAIT_ENABLE_CYC (`EEIU_UNLIMITED_WAIT_ENABLE_NS / `EEIU_CLK_NS)
`endif

// ==== eeiu_host_model.sv ====
`timescale 1ns/100ps
// ==========================================
// host side: counts falling edges of the interrupt pin
module eeiu_host_model (
	input  wire logic       clock_i,
	input  wire logic       sys_rst_i,
	input  wire logic       int_n_i,
	output logic      [7:0] falls_o
);
	logic       seen_ff;
	logic       nxt_seen;
	logic [7:0] falls_ff;
	logic [7:0] nxt_falls;
	// edge sensing only, so a pin that never rises again is never counted twice
	always_comb begin
		nxt_seen = int_n_i;
		nxt_falls = falls_ff + {7'h00, seen_ff & ~int_n_i};
	end
	// idle pin level is high, so reset assumes high
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			seen_ff <= 1'b1;
			falls_ff <= 8'h00;
		end else begin
			seen_ff <= nxt_seen;
			falls_ff <= nxt_falls;
		end
	end
	assign falls_o = falls_ff;
endmodule

// ==== eeiu_pkg.sv ====
package eeiu_pkg;
	// transmit engine states
	typedef enum logic [0:0] {
		EEIU_TX_IDLE,
		EEIU_TX_BUSY
	} eeiu_tx_st_t;
	// register port request, one cycle per access
	typedef struct packed {
		logic        wr;
		logic        bfc;
		logic        rd;
		logic [1:0]  sel;
		logic [15:0] wdata;
	} eeiu_reg_req_t;
	// transmit engine events
	typedef struct packed {
		logic        start;
		logic        done;
		logic        cancel;
		logic        coll_excess;
		logic        coll_window;
		logic        coll_after64;
		logic        medium_busy;
		logic        per_packet_override;
		logic        per_packet_huge_enable;
		logic [15:0] frame_len;
	} eeiu_tx_evt_t;
	// receive engine events
	typedef struct packed {
		logic frame_done;
		logic out_of_space;
		logic packet_count_decrement;
	} eeiu_rx_evt_t;
endpackage

// ==== eeiu_top.sv ====
`timescale 1ns/100ps
`include "eeiu_defs.svh"
// How it works
// R1: enable bit 7 gates the interrupt pin; when clear the pin stays high.
// R2: enable bits 6,5,4,3,1,0 select sources; bit 2 reserved; all reset zero.
// R3: flags share enable positions; bit 7 reads zero; some flags read-only.
// R4: packet flag follows nonzero packet count; clears when decrement empties it.
// R5: copy-engine flag sets on copy or checksum end and stays set until host clear or reset.
// R6: link flag follows phy; clears through phy flag register read or by clearing either phy enable.
// R7: phy enable keeps only bits 4 and 1; the rest read zero.
// R8: phy link flag sets on link change, self-clears on phy flag read.
// R9: phy global flag sets on enabled phy event, self-clears on read.
// R10: receive aborts with error on no space or count 255.
// R11: receive error flag is sticky until host clear or reset.
// R12: receive error drives the pin only with both its enables set.
// R13: host drains packets, frees space, then clears the receive error.
// R14: collision aborts from retry limit, window or after 64 bytes.
// R15: deferral limit expiry aborts unless unlimited wait is enabled.
// R16: oversize frame aborts unless huge or per-packet huge is allowed.
// R17: transmit error is sticky; pin low while flag and enables set.
// R18: abort clears request, sets abort status, writes status past end.
// R19: host clears late collision and abort status after diagnosis.
// R20: in full duplex only the oversize and deferral limit cases can abort.
// R21: transmit error always sets transmit done at the same time.
// R22: transmit done sets on completion, abort or host cancel.
// R23: pin low while any enabled flag is set and global enable on.
// R24: link flag mirrors phy global flag only with both phy enables.
// R25: restoring the global enable with a pending flag gives a new edge.
// R26: flags other than link set regardless of any enable.
// R27: a set in the same cycle as a clear wins.
module eeiu_top import eeiu_pkg::*; #(
	parameter int PTR_W     = 13,
	parameter int CNT_W     = 17,
	parameter int UNLIMITED_WAIT_ENABLE_CYC = `EEIU_UNLIMITED_WAIT_ENABLE_CYC
) (
	input  wire logic             clock_i,
	input  wire logic             sys_rst_i,
	input  wire eeiu_reg_req_t    reg_i,
	input  wire eeiu_tx_evt_t     tx_evt_i,
	input  wire eeiu_rx_evt_t     rx_evt_i,
	input  wire logic             copy_done_i,
	input  wire logic             link_change_i,
	input  wire logic             full_duplex_i,
	input  wire logic             unlimited_wait_enable_i,
	input  wire logic             huge_frame_enable_i,
	input  wire logic [15:0]      max_frame_length_i,
	input  wire logic [PTR_W-1:0] tx_end_pointer_i,
	input  wire logic             tx_abort_clear_i,
	input  wire logic             late_collision_clear_i,
	output logic [15:0]           rdata_o,
	output logic                  int_n_o,
	output logic                  tx_request_o,
	output logic                  tx_abort_status_o,
	output logic                  late_collision_status_o,
	output logic                  tx_status_we_o,
	output logic [PTR_W-1:0]      tx_status_addr_o,
	output logic                  rx_abort_o,
	output logic [7:0]            packet_count_o
);

	// ==========================================
	// state
	eeiu_tx_st_t      tx_st_ff, nxt_tx_st;
	logic             tx_req_ff, nxt_tx_req;
	logic             abrt_ff, nxt_abrt;
	logic             lcol_ff, nxt_lcol;
	logic             swe_ff, nxt_swe;
	logic [PTR_W-1:0] saddr_ff, nxt_saddr;
	logic [CNT_W-1:0] dfr_ff, nxt_dfr;
	logic [7:0]       cnt_ff, nxt_cnt;
	logic             rxab_ff, nxt_rxab;
	logic [7:0]       en_ff, nxt_en;
	logic [7:0]       flag_ff, nxt_flag;
	logic [15:0]      pen_ff, nxt_pen;
	logic             plnk_ff, nxt_plnk;
	logic             phy_global_flag_ff, nxt_phy_global_flag;
	logic [15:0]      rd_ff, nxt_rd;
	logic             int_n_ff, nxt_int_n;
	logic             tx_abort, tx_end, rx_err;

	// true when a frame of this length is refused at start
	function automatic logic too_long(input eeiu_tx_evt_t e);
		too_long = (e.frame_len > max_frame_length_i) && !huge_frame_enable_i
			&& !(e.per_packet_override && e.per_packet_huge_enable);
	endfunction

	// ==========================================
	// transmit sequencing; no automatic retry after an abort
	always_comb begin
		nxt_tx_st = tx_st_ff;
		nxt_tx_req = tx_req_ff;
		nxt_dfr = dfr_ff;
		nxt_swe = 1'b0;
		nxt_saddr = saddr_ff;
		nxt_lcol = lcol_ff & ~late_collision_clear_i;
		nxt_abrt = abrt_ff & ~tx_abort_clear_i;
		tx_abort = 1'b0;
		tx_end = 1'b0;
		unique case (tx_st_ff)
			EEIU_TX_IDLE: begin
				nxt_dfr = '0;
				if (tx_evt_i.start) begin
					if (too_long(tx_evt_i)) begin
						tx_abort = 1'b1; // R16 R20
					end else begin
						nxt_tx_st = EEIU_TX_BUSY;
						nxt_tx_req = 1'b1;
					end
				end
			end
			EEIU_TX_BUSY: begin
				// deferral only counts while the medium is held busy
				if (tx_evt_i.medium_busy) begin
					nxt_dfr = dfr_ff + CNT_W'(`EEIU_PTR_ONE);
				end
				if (!full_duplex_i && (tx_evt_i.coll_excess || tx_evt_i.coll_window
						|| tx_evt_i.coll_after64)) begin
					tx_abort = 1'b1; // R14 R20
				end
				if (tx_evt_i.medium_busy && !unlimited_wait_enable_i
						&& dfr_ff >= CNT_W'(UNLIMITED_WAIT_ENABLE_CYC - 1)) begin
					tx_abort = 1'b1; // R15
				end
				if (tx_abort || tx_evt_i.done || tx_evt_i.cancel) begin
					tx_end = 1'b1; // R22
					nxt_tx_st = EEIU_TX_IDLE;
					nxt_tx_req = 1'b0;
				end
			end
		endcase
		if (!full_duplex_i && tx_st_ff == EEIU_TX_BUSY && tx_evt_i.coll_after64) begin
			nxt_lcol = 1'b1;
		end
		if (tx_abort) begin
			tx_end = 1'b1; // R22
			nxt_abrt = 1'b1; // R18
			nxt_swe = 1'b1; // R18
			nxt_saddr = tx_end_pointer_i + PTR_W'(`EEIU_PTR_ONE); // R18
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			tx_st_ff <= EEIU_TX_IDLE;
			tx_req_ff <= 1'b0;
			abrt_ff <= 1'b0;
			lcol_ff <= 1'b0;
			swe_ff <= 1'b0;
			saddr_ff <= '0;
			dfr_ff <= '0;
		end else begin
			tx_st_ff <= nxt_tx_st;
			tx_req_ff <= nxt_tx_req;
			abrt_ff <= nxt_abrt;
			lcol_ff <= nxt_lcol;
			swe_ff <= nxt_swe;
			saddr_ff <= nxt_saddr;
			dfr_ff <= nxt_dfr;
		end
	end

	// ==========================================
	// packet count; a full count or full buffer drops the packet
	always_comb begin
		nxt_cnt = cnt_ff;
		rx_err = rx_evt_i.out_of_space
			|| (rx_evt_i.frame_done && cnt_ff == `EEIU_PKT_MAX); // R10
		if (rx_evt_i.frame_done && !rx_err) begin
			nxt_cnt = nxt_cnt + `EEIU_PKT_ONE;
		end
		if (rx_evt_i.packet_count_decrement && cnt_ff != `EEIU_RST8) begin
			nxt_cnt = nxt_cnt - `EEIU_PKT_ONE; // R4
		end
		nxt_rxab = rx_err; // R10
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			cnt_ff <= `EEIU_RST8;
			rxab_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			rxab_ff <= nxt_rxab;
		end
	end

	// ==========================================
	// registers, flags and interrupt pin
	always_comb begin
		logic [7:0] clr;
		logic [7:0] set;
		logic       prd;
		clr = `EEIU_RST8;
		set = `EEIU_RST8;
		prd = reg_i.rd && reg_i.sel == `EEIU_SEL_PFLAG;
		nxt_en = en_ff;
		nxt_pen = pen_ff;
		if (reg_i.wr && reg_i.sel == `EEIU_SEL_EN) begin
			nxt_en = reg_i.wdata[7:0] & `EEIU_EN_WMASK; // R2
		end
		if (reg_i.bfc && reg_i.sel == `EEIU_SEL_EN) begin
			nxt_en = en_ff & ~reg_i.wdata[7:0];
		end
		if (reg_i.wr && reg_i.sel == `EEIU_SEL_PEN) begin
			nxt_pen = reg_i.wdata & `EEIU_PEN_WMASK; // R7
		end
		// phy flags: a change in the read cycle survives the read
		nxt_plnk = (plnk_ff & ~prd) | link_change_i; // R8 R27
		nxt_phy_global_flag = (phy_global_flag_ff & ~prd) | (link_change_i
			& pen_ff[`EEIU_B_PLNK] & pen_ff[`EEIU_B_PGEN]); // R9 R27
		// only the clearable flags respond to writes
		if (reg_i.wr && reg_i.sel == `EEIU_SEL_FLAG) begin
			clr = ~reg_i.wdata[7:0] & `EEIU_FLG_CMASK; // R3
		end
		if (reg_i.bfc && reg_i.sel == `EEIU_SEL_FLAG) begin
			clr = reg_i.wdata[7:0] & `EEIU_FLG_CMASK; // R3
		end
		set[`EEIU_B_DMA] = copy_done_i; // R5 R26
		set[`EEIU_B_TXD] = tx_end; // R21 R22 R26
		set[`EEIU_B_TXE] = tx_abort; // R14 R15 R16 R26
		set[`EEIU_B_RXE] = rx_err; // R10 R26
		nxt_flag = (flag_ff & ~clr) | set; // R11 R17 R27
		nxt_flag[`EEIU_B_PKT] = nxt_cnt != `EEIU_RST8; // R4
		nxt_flag[`EEIU_B_LNK] = nxt_phy_global_flag & nxt_pen[`EEIU_B_PLNK]
			& nxt_pen[`EEIU_B_PGEN]; // R6 R24
		nxt_flag[`EEIU_B_GIE] = 1'b0; // R3
		nxt_flag[`EEIU_B_RSV] = 1'b0;
		// pin is registered from the next gated flags, so it changes on the same edge as the flags
		nxt_int_n = !(nxt_en[`EEIU_B_GIE] && |(nxt_flag & nxt_en)); // R1 R12 R17 R23 R25
		// read data holds the value before any read-clear
		nxt_rd = `EEIU_RST16;
		if (reg_i.rd) begin
			unique case (reg_i.sel)
				`EEIU_SEL_EN:   nxt_rd[7:0] = en_ff;
				`EEIU_SEL_FLAG: nxt_rd[7:0] = flag_ff;
				`EEIU_SEL_PEN:  nxt_rd = pen_ff;
				`EEIU_SEL_PFLAG: begin
					nxt_rd[`EEIU_B_PLNK] = plnk_ff;
					nxt_rd[`EEIU_B_PHY_GLOBAL_FLAG] = phy_global_flag_ff;
				end
			endcase
		end else begin
			nxt_rd = rd_ff;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			en_ff <= `EEIU_RST8;
			flag_ff <= `EEIU_RST8;
			pen_ff <= `EEIU_RST16;
			plnk_ff <= 1'b0;
			phy_global_flag_ff <= 1'b0;
			rd_ff <= `EEIU_RST16;
			int_n_ff <= 1'b1;
		end else begin
			en_ff <= nxt_en;
			flag_ff <= nxt_flag;
			pen_ff <= nxt_pen;
			plnk_ff <= nxt_plnk;
			phy_global_flag_ff <= nxt_phy_global_flag;
			rd_ff <= nxt_rd;
			int_n_ff <= nxt_int_n;
		end
	end

	// outputs straight from flops
	assign rdata_o = rd_ff;
	assign int_n_o = int_n_ff;
	assign tx_request_o = tx_req_ff;
	assign tx_abort_status_o = abrt_ff;
	assign late_collision_status_o = lcol_ff;
	assign tx_status_we_o = swe_ff;
	assign tx_status_addr_o = saddr_ff;
	assign rx_abort_o = rxab_ff;
	assign packet_count_o = cnt_ff;

	// ==========================================
	// checks
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (sys_rst_i);

	gie_off_high_a: assert property (!en_ff[`EEIU_B_GIE] |-> int_n_o) // R1
		else $error("pin low with global enable clear");
	int_low_a: assert property (en_ff[`EEIU_B_GIE] && |(flag_ff & en_ff) |-> !int_n_o) // R23
		else $error("pin high with enabled flag pending");
	txerr_done_a: assert property ($rose(flag_ff[`EEIU_B_TXE]) |-> $rose(flag_ff[`EEIU_B_TXD])
		|| $past(flag_ff[`EEIU_B_TXD])) // R21
		else $error("transmit error without transmit done");
	pkt_flag_a: assert property (flag_ff[`EEIU_B_PKT] == (packet_count_o != `EEIU_RST8)) // R4
		else $error("packet flag disagrees with count");
	link_mirror_a: assert property (flag_ff[`EEIU_B_LNK] == (phy_global_flag_ff
		&& pen_ff[`EEIU_B_PLNK] && pen_ff[`EEIU_B_PGEN])) // R24
		else $error("link flag does not mirror phy flag");
	phy_rd_clr_a: assert property (reg_i.rd && reg_i.sel == `EEIU_SEL_PFLAG && !link_change_i
		|=> !plnk_ff && !phy_global_flag_ff && !flag_ff[`EEIU_B_LNK]) // R8
		else $error("phy flags survive read");
	rx_full_a: assert property (rx_evt_i.frame_done && packet_count_o == `EEIU_PKT_MAX
		|=> rx_abort_o && flag_ff[`EEIU_B_RXE] && packet_count_o == ($past(rx_evt_i.packet_count_decrement)
		? `EEIU_PKT_MAX - `EEIU_PKT_ONE : `EEIU_PKT_MAX)) // R10
		else $error("packet at count limit not aborted");
	rxerr_keep_a: assert property (flag_ff[`EEIU_B_RXE]
		&& !((reg_i.wr || reg_i.bfc) && reg_i.sel == `EEIU_SEL_FLAG) |=> flag_ff[`EEIU_B_RXE]) // R11
		else $error("receive error lost without clear");
	tx_abort_a: assert property (tx_abort |=> !tx_request_o && tx_abort_status_o
		&& tx_status_we_o && flag_ff[`EEIU_B_TXE] ##1 !tx_status_we_o) // R18
		else $error("abort effects missing");
	set_wins_a: assert property (copy_done_i |=> flag_ff[`EEIU_B_DMA]) // R27
		else $error("copy done lost");
endmodule

// ==== eeiu_top_tb.sv ====
`timescale 1ns/100ps
module eeiu_top_tb import eeiu_pkg::*; ;
	logic          clock_i = 0;
	logic          sys_rst_i = 1;
	eeiu_reg_req_t rq = '0;
	logic [5:0]    tp = '0;
	logic [2:0]    rp = '0;
	logic          cp = 0, lc = 0, fd = 0, uw = 0, hf = 0, tac = 0, lcc = 0, mb = 0, w;
	logic [15:0]   mfl = 16'h0100, fl = 16'h0100, rv;
	logic [1:0]    pp = '0;
	logic [12:0]   ep = 13'h0000;
	logic [31:0]   seed = 32'h0000cd06;
	int            n_mismatch = 0, n_tests = 0;
	logic [15:0]   rdata;
	logic [12:0]   sad;
	logic [7:0]    pc, falls;
	logic          int_n, txr, tabs, lcs, swe, rxa;
	// pulses live in plain vectors so one assignment clears them all
	wire eeiu_tx_evt_t te = {tp, mb, pp, fl};
	wire eeiu_rx_evt_t re = rp;
	eeiu_top #(.UNLIMITED_WAIT_ENABLE_CYC(20)) eeiu_top_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_i(rq), .tx_evt_i(te),
		.rx_evt_i(re), .copy_done_i(cp), .link_change_i(lc), .full_duplex_i(fd), .unlimited_wait_enable_i(uw),
		.huge_frame_enable_i(hf), .max_frame_length_i(mfl), .tx_end_pointer_i(ep), .tx_abort_clear_i(tac),
		.late_collision_clear_i(lcc), .rdata_o(rdata), .int_n_o(int_n), .tx_request_o(txr),
		.tx_abort_status_o(tabs), .late_collision_status_o(lcs), .tx_status_we_o(swe),
		.tx_status_addr_o(sad), .rx_abort_o(rxa), .packet_count_o(pc));
	eeiu_host_model eeiu_host_model_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .int_n_i(int_n), .falls_o(falls));
	// ==========================================
	// helpers
	initial forever #10 clock_i = ~clock_i;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic logic int_exp(input logic [7:0] en, input logic [7:0] fl);
		return !(en[7] && |(en[6:0] & fl[6:0]));
	endfunction
	task automatic tally_and_finish();
		if (n_mismatch == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic step();
		@(negedge clock_i);
		tp = '0;
		rp = '0;
		{cp, lc, tac, lcc} = 4'h0;
	endtask
	// k is {wr, bfc, rd}; read data lands one edge after the request
	task automatic acc(input logic [2:0] k, input logic [1:0] s, input logic [15:0] d);
		@(negedge clock_i);
		{rq.wr, rq.bfc, rq.rd} = k;
		rq.sel = s;
		rq.wdata = d;
		@(negedge clock_i);
		rq = '0;
		rv = rdata;
	endtask
	// how: 0 done, 1 cancel, 2..4 collisions, 5 no ending event
	task automatic txrun(input logic [15:0] len, input int how);
		@(negedge clock_i);
		tp[5] = 1;
		fl = len;
		step();
		w = swe;
		if (how < 5) begin
			@(negedge clock_i);
			tp[4-how] = 1;
			step();
			w = w | swe;
		end
		step();
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 100 && txr; i++) step();
		if (txr) begin
			n_mismatch++;
			$display("BAD %0t transmit hang", $time);
			tally_and_finish();
		end
	endtask
	// ==========================================
	// main sequence
	initial begin
		repeat (5) @(posedge clock_i);
		@(negedge clock_i);
		sys_rst_i = 0;
		for (int s = 0; s < 4; s++) begin
			acc(3'b001, s[1:0], 16'h0000);
			chk(rv, 16'h0000);
		end
		chk(int_n, 1'b1);
		// link change with the phy enables still at reset: only the phy link flag records it
		@(negedge clock_i);
		lc = 1;
		step();
		acc(3'b001, 2'h1, 16'h0000);
		chk(rv, 16'h0000);
		acc(3'b001, 2'h3, 16'h0000);
		chk(rv, 16'h0010);
		acc(3'b100, 2'h0, 16'hffff);
		acc(3'b001, 2'h0, 16'h0000);
		chk(rv, 16'h00fb);
		acc(3'b100, 2'h2, 16'hffff);
		acc(3'b001, 2'h2, 16'h0000);
		chk(rv, 16'h0012);
		// copy end pulls the pin low; dropping and restoring the global enable re-arms the edge
		@(negedge clock_i);
		cp = 1;
		repeat (2) step();
		acc(3'b001, 2'h1, 16'h0000);
		chk(rv, 16'h0020);
		chk(int_n, int_exp(8'hfb, rv[7:0]));
		acc(3'b100, 2'h0, 16'h007b);
		step();
		chk(int_n, 1'b1);
		acc(3'b100, 2'h0, 16'h00fb);
		repeat (2) step();
		chk(falls, 16'h0002);
		// clear and set in the same cycle: the set survives
		@(negedge clock_i);
		{cp, lc} = 2'b11;
		{rq.bfc, rq.sel, rq.wdata} = {1'b1, 2'h1, 16'h0020};
		step();
		rq = '0;
		acc(3'b001, 2'h1, 16'h0000);
		chk(rv, 16'h0030);
		acc(3'b001, 2'h3, 16'h0000);
		chk(rv, 16'h0014);
		acc(3'b001, 2'h1, 16'h0000);
		chk(rv, 16'h0020);
		acc(3'b100, 2'h1, 16'h0000);
		acc(3'b001, 2'h1, 16'h0000);
		chk(rv, 16'h0000);
		chk(int_n, 1'b1);
		// receive: fill the count, then both abort causes with only the error enabled
		acc(3'b100, 2'h0, 16'h0081);
		repeat (255) begin
			@(negedge clock_i);
			rp = 3'b100;
			step();
		end
		acc(3'b001, 2'h1, 16'h0000);
		chk(rv, 16'h0040);
		for (int k = 0; k < 2; k++) begin
			@(negedge clock_i);
			rp = k ? 3'b010 : 3'b100;
			step();
			chk(rxa, 1'b1);
			chk(pc, 16'h00ff);
		end
		step();
		chk(int_n, 1'b0);
		repeat (256) begin
			@(negedge clock_i);
			rp = 3'b001;
			step();
		end
		acc(3'b001, 2'h1, 16'h0000);
		chk(rv, 16'h0001);
		acc(3'b010, 2'h1, 16'h0001);
		acc(3'b001, 2'h1, 16'h0000);
		chk(rv | pc, 16'h0000);
		chk(int_n, 1'b1);
		// transmit endings, random end pointer and length limit
		seed = xs(seed);
		ep = seed[12:0];
		acc(3'b100, 2'h0, 16'h008a);
		for (int h = 0; h < 6; h++) begin
			txrun(mfl + ((h == 5) ? (16'h0001 + {12'h000, seed[3:0]}) : 16'h0000), h);
			acc(3'b001, 2'h1, 16'h0000);
			chk(rv, (h >= 2) ? 16'h000a : 16'h0008);
			chk({txr, tabs, w}, (h >= 2) ? 16'h0003 : 16'h0000);
			chk(lcs, h == 4);
			chk(sad, (h >= 2) ? 13'(ep + 13'h0001) : 13'h0000);
			chk(int_n, int_exp(8'h8a, rv[7:0]));
			@(negedge clock_i);
			{tac, lcc} = 2'b11;
			step();
			acc(3'b010, 2'h1, 16'h000a);
			chk({tabs, lcs, int_n}, 16'h0001);
		end
		// oversize frame: huge enable, per-packet huge, then override alone which must abort
		for (int p = 0; p < 3; p++) begin
			{hf, pp} = (p == 0) ? 3'b100 : ((p == 1) ? 3'b011 : 3'b010);
			txrun(mfl + 16'h0010, (p == 2) ? 5 : 0);
			acc(3'b001, 2'h1, 16'h0000);
			chk(rv, (p == 2) ? 16'h000a : 16'h0008);
			acc(3'b010, 2'h1, 16'h000a);
		end
		{hf, pp} = 3'b000;
		fd = 1;
		txrun(mfl, 2);
		chk(txr, 1'b1);
		@(negedge clock_i);
		tp[4] = 1;
		step();
		fd = 0;
		// deferral limit, then the same wait with unlimited wait on
		for (int u = 0; u < 2; u++) begin
			acc(3'b010, 2'h1, 16'h000a);
			uw = u[0];
			txrun(mfl, 5);
			mb = 1;
			repeat (40) step();
			chk(txr, u[0]);
			mb = 0;
			if (u == 1) begin
				@(negedge clock_i);
				tp[4] = 1;
				step();
			end
			wait_idle();
			acc(3'b001, 2'h1, 16'h0000);
			chk(rv, u ? 16'h0008 : 16'h000a);
		end
		tally_and_finish();
	end
endmodule
